// ### hfc_ctrl.sv
// host controller that sequences commands into a multi-bank nor flash
// What this block does
// - bad sequence recovered by writing reset
// - host resets after timeout or autoselect
// - autoselect: two unlocks then bank command
// - autoselect only from read, none busy
// - word program is four write cycles
// - bypass: 20h entry, A0h two-cycle program
`timescale 1ns/1ps
`include "hfc_params.svh"
module hfc_ctrl (
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [`HFC_PAW-1:0] paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [`HFC_AW-1:0]       fl_addr,
  input  wire logic [`HFC_DW-1:0]  fl_dq_i,
  output logic [`HFC_DW-1:0]       fl_dq_o,
  output logic                     fl_dq_oe_n,
  output logic                     fl_ce_n,
  output logic                     fl_we_n,
  output logic                     fl_oe_n,
  input  wire logic                ready_busy_n,
  output logic                     accel_high_voltage
);
  import hfc_pkg::*;
  localparam int NB = `HFC_NBANK;

  hfc_cyc_if cyc ();

  logic [31:0] ctrl_r, addr_r, data_r, code_r, code2_r, unlk1_r, unlk2_r;
  logic [`HFC_DW-1:0] rdata_r, prev_r;
  hfc_op_t     op_r;
  hfc_state_t  st_r;
  hfc_mode_t   mode_r [NB];
  hfc_susp_t   susp_r [NB];
  logic        sec_r, err_r, refuse_r, pfail_r, wait_r, to_r, ret_byp_r;
  logic [1:0]  idx_r, last_r, bank;
  logic [`HFC_AW-1:0] sa_r [`HFC_SEQ_MAX];
  logic [`HFC_DW-1:0] sd_r [`HFC_SEQ_MAX];
  logic [`HFC_AW-1:0] na [`HFC_SEQ_MAX];
  logic [`HFC_DW-1:0] nd [`HFC_SEQ_MAX];
  logic [1:0]  nlast;
  logic        wr_en, rd_en, hit, start, legal, any_busy, byp, accel;
  logic        cyc_done, last_rd, fin, abort_done;
  hfc_op_t     nop;
  logic [31:0] stat;
  logic [`HFC_AW-1:0] u1a, u2a;
  logic [`HFC_DW-1:0] u1d, u2d;

  // apb slave: zero wait states, error on unmapped words
  assign pready = 1'b1;
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  always_comb begin
    hit = 1'b1;
    case (paddr)
      `HFC_OFS_CTRL:  prdata = ctrl_r;
      `HFC_OFS_ADDR:  prdata = addr_r;
      `HFC_OFS_DATA:  prdata = data_r;
      `HFC_OFS_CODE:  prdata = code_r;
      `HFC_OFS_CODE2: prdata = code2_r;
      `HFC_OFS_UNLK1: prdata = unlk1_r;
      `HFC_OFS_UNLK2: prdata = unlk2_r;
      `HFC_OFS_STAT:  prdata = stat;
      `HFC_OFS_RDATA: prdata = {16'h0000, rdata_r};
      default: begin
        prdata = 32'h0000_0000;
        hit    = 1'b0;
      end
    endcase
  end
  assign pslverr = psel && penable && !hit;

  assign bank  = addr_r[`HFC_BANK_HI:`HFC_BANK_LO];
  assign nop   = hfc_op_t'(pwdata[`HFC_CTRL_OP]);
  assign start = wr_en && paddr == `HFC_OFS_CTRL;
  // secured region masks the accel request off the pin
  assign accel = ctrl_r[`HFC_CTRL_ACCEL] && !sec_r;
  assign accel_high_voltage = accel;
  // accel forces the device into bypass for every bank
  assign byp = mode_r[bank] == M_BYP || accel;

  always_comb begin
    any_busy = 1'b0;
    for (int i = 0; i < NB; i++) begin
      if (mode_r[i] == M_BUSY) any_busy = 1'b1;
    end
  end

  // only orders that the device state allows are put on the pins
  always_comb begin
    case (nop)
      OP_RAW_WR, OP_READ: legal = 1'b1;
      OP_RESET:     legal = !byp;
      OP_AUTOSEL:   legal = mode_r[bank] == M_READ && !any_busy;
      OP_BYP_ENTER: legal = mode_r[bank] == M_READ && !sec_r;
      OP_SEC_ENTER: legal = mode_r[bank] == M_READ && !any_busy;
      OP_SEC_EXIT:  legal = sec_r;
      OP_PROGRAM:   legal = mode_r[bank] == M_READ && !accel;
      OP_BYP_PROG:  legal = byp && !sec_r;
      OP_BYP_RESET: legal = mode_r[bank] == M_BYP;
      OP_ESUSP:     legal = mode_r[bank] == M_READ &&
                            susp_r[bank] == SU_NONE;
      OP_PSUSP:     legal = mode_r[bank] == M_READ &&
                            susp_r[bank] == SU_NONE;
      default:      legal = 1'b0;
    endcase
  end

  // unlock patterns and all command codes except F0h, 20h, A0h and B0h come from software registers
  assign u1a = `HFC_AW'(unlk1_r[`HFC_UNLK_ADDR]);
  assign u2a = `HFC_AW'(unlk2_r[`HFC_UNLK_ADDR]);
  assign u1d = `HFC_DW'(unlk1_r[`HFC_UNLK_DATA]);
  assign u2d = `HFC_DW'(unlk2_r[`HFC_UNLK_DATA]);

  always_comb begin
    for (int i = 0; i < `HFC_SEQ_MAX; i++) begin
      na[i] = u1a;
      nd[i] = u1d;
    end
    na[1] = u2a;
    nd[1] = u2d;
    na[2] = addr_r[`HFC_AW-1:0];
    nd[2] = data_r[`HFC_DW-1:0];
    nlast = 2'd2;
    case (nop)
      OP_RAW_WR, OP_READ: begin
        na[0] = addr_r[`HFC_AW-1:0];
        nd[0] = data_r[`HFC_DW-1:0];
        nlast = 2'd0;
      end
      OP_RESET, OP_ESUSP, OP_PSUSP: begin
        na[0] = addr_r[`HFC_AW-1:0];
        nd[0] = (nop == OP_RESET) ? `HFC_DW'(`HFC_RESET_CMD) :
                (nop == OP_ESUSP) ? `HFC_DW'(`HFC_ESUS_CMD) :
                `HFC_DW'(code2_r[`HFC_CODE2_PSUS]);
        nlast = 2'd0;
      end
      OP_AUTOSEL: nd[2] = `HFC_DW'(code_r[`HFC_CODE_AUTO]);
      OP_BYP_ENTER: nd[2] = `HFC_DW'(`HFC_BYPIN_CMD);
      OP_SEC_ENTER: nd[2] = `HFC_DW'(code_r[`HFC_CODE_SECIN]);
      OP_SEC_EXIT: begin
        nd[2] = `HFC_DW'(code_r[`HFC_CODE_SECXA]);
        nd[3] = `HFC_DW'(code_r[`HFC_CODE_SECXB]);
        na[3] = addr_r[`HFC_AW-1:0];
        nlast = 2'd3;
      end
      OP_PROGRAM: begin
        nd[2] = `HFC_DW'(code2_r[`HFC_CODE2_PSET]);
        na[3] = addr_r[`HFC_AW-1:0];
        nd[3] = data_r[`HFC_DW-1:0];
        nlast = 2'd3;
      end
      OP_BYP_PROG, OP_BYP_RESET: begin
        na[0] = addr_r[`HFC_AW-1:0];
        nd[0] = (nop == OP_BYP_PROG) ? `HFC_DW'(`HFC_BYPPG_CMD) :
                `HFC_DW'(code2_r[`HFC_CODE2_BRA]);
        na[1] = addr_r[`HFC_AW-1:0];
        nd[1] = (nop == OP_BYP_PROG) ? data_r[`HFC_DW-1:0] :
                `HFC_DW'(code2_r[`HFC_CODE2_BRB]);
        nlast = 2'd1;
      end
      default: nlast = 2'd0;
    endcase
  end

  // cycle engine handshake
  assign cyc.req   = st_r != S_IDLE && !wait_r;
  assign cyc.wr    = (st_r == S_CYC && op_r != OP_READ) || st_r == S_ABORT;
  assign cyc.addr  = (st_r == S_CYC) ? sa_r[idx_r] : addr_r[`HFC_AW-1:0];
  assign cyc.wdata = (st_r == S_ABORT) ? `HFC_DW'(`HFC_RESET_CMD) :
                     sd_r[idx_r];
  assign cyc_done  = cyc.done;
  assign last_rd   = cyc.rdata[`HFC_DQ_TOGGLE];
  // completion of a poll: toggle bit stood still between two reads
  assign fin = st_r == S_POLL && cyc_done && idx_r != 2'd0 &&
               last_rd == prev_r[`HFC_DQ_TOGGLE];
  assign abort_done = st_r == S_ABORT && cyc_done;

  hfc_cycle u_cycle (
    .ref_clk    (ref_clk),
    .rstn       (rstn),
    .cyc        (cyc),
    .fl_addr    (fl_addr),
    .fl_dq_i    (fl_dq_i),
    .fl_dq_o    (fl_dq_o),
    .fl_dq_oe_n (fl_dq_oe_n),
    .fl_ce_n    (fl_ce_n),
    .fl_we_n    (fl_we_n),
    .fl_oe_n    (fl_oe_n)
  );

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_r  <= 32'h0000_0000;
      addr_r  <= 32'h0000_0000;
      data_r  <= 32'h0000_0000;
      code_r  <= `HFC_CODE_RST;
      code2_r <= `HFC_CODE_RST;
      unlk1_r <= `HFC_UNLK_RST;
      unlk2_r <= `HFC_UNLK_RST;
    end else if (wr_en) begin
      case (paddr)
        `HFC_OFS_CTRL:  if (st_r == S_IDLE) ctrl_r <= pwdata;
        `HFC_OFS_ADDR:  addr_r  <= pwdata;
        `HFC_OFS_DATA:  data_r  <= pwdata;
        `HFC_OFS_CODE:  code_r  <= pwdata;
        `HFC_OFS_CODE2: code2_r <= pwdata;
        `HFC_OFS_UNLK1: unlk1_r <= pwdata;
        `HFC_OFS_UNLK2: unlk2_r <= pwdata;
        default: ;
      endcase
    end
  end

  // sequencer
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r   <= S_IDLE;
      op_r   <= OP_RAW_WR;
      idx_r  <= 2'd0;
      last_r <= 2'd0;
      wait_r <= 1'b0;
      to_r   <= 1'b0;
      prev_r <= '0;
      for (int i = 0; i < `HFC_SEQ_MAX; i++) begin
        sa_r[i] <= '0;
        sd_r[i] <= '0;
      end
    end else begin
      if (cyc.req) wait_r <= 1'b1;
      if (cyc_done) wait_r <= 1'b0;
      case (st_r)
        S_IDLE: begin
          if (start && legal) begin
            op_r   <= nop;
            idx_r  <= 2'd0;
            last_r <= nlast;
            to_r   <= 1'b0;
            sa_r   <= na;
            sd_r   <= nd;
            st_r   <= S_CYC;
          end
        end
        S_CYC: begin
          if (cyc_done) begin
            if (idx_r != last_r) begin
              idx_r <= idx_r + 2'd1;
            end else if (op_r == OP_PROGRAM || op_r == OP_BYP_PROG) begin
              idx_r <= 2'd0;
              st_r  <= S_POLL;
            end else begin
              st_r <= S_IDLE;
            end
          end
        end
        S_POLL: begin
          if (cyc_done) begin
            prev_r <= cyc.rdata;
            idx_r  <= 2'd1;
            if (fin) begin
              st_r <= S_IDLE;
            end else if (idx_r != 2'd0 && to_r) begin
              st_r <= S_ABORT;
            end else if (idx_r != 2'd0) begin
              to_r <= cyc.rdata[`HFC_DQ_TIMEOUT];
            end
          end
        end
        S_ABORT: if (cyc_done) st_r <= S_IDLE;
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // per-bank modes; reset is only sent when the addressed bank is not in bypass and accel is low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sec_r     <= 1'b0;
      ret_byp_r <= 1'b0;
      for (int i = 0; i < NB; i++) begin
        mode_r[i] <= M_READ;
        susp_r[i] <= SU_NONE;
      end
    end else if (st_r == S_IDLE && start && legal) begin
      case (nop)
        OP_RESET: begin
          for (int i = 0; i < NB; i++) begin
            if (mode_r[i] == M_AUTO) mode_r[i] <= M_READ;
          end
          mode_r[bank] <= M_READ;
        end
        OP_AUTOSEL:   mode_r[bank] <= M_AUTO;
        OP_BYP_ENTER: mode_r[bank] <= M_BYP;
        OP_BYP_RESET: mode_r[bank] <= M_READ;
        OP_SEC_ENTER: sec_r <= 1'b1;
        OP_SEC_EXIT:  sec_r <= 1'b0;
        OP_ESUSP:     susp_r[bank] <= SU_ERASE;
        OP_PSUSP:     susp_r[bank] <= SU_PROG;
        OP_PROGRAM, OP_BYP_PROG: begin
          ret_byp_r    <= mode_r[bank] == M_BYP;
          mode_r[bank] <= M_BUSY;
        end
        default: ;
      endcase
    end else if (fin) begin
      // suspend kind is kept; the bank returns to bypass if it programmed from bypass, else to read
      mode_r[bank] <= ret_byp_r ? M_BYP : M_READ;
    end else if (abort_done) begin
      mode_r[bank] <= M_READ;
    end
  end

  // status flags: hardware set wins over a same-cycle w1c clear
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      err_r    <= 1'b0;
      refuse_r <= 1'b0;
      pfail_r  <= 1'b0;
      rdata_r  <= '0;
    end else begin
      if (wr_en && paddr == `HFC_OFS_STAT) begin
        if (pwdata[`HFC_ST_ERR])    err_r    <= 1'b0;
        if (pwdata[`HFC_ST_REFUSE]) refuse_r <= 1'b0;
        if (pwdata[`HFC_ST_PFAIL])  pfail_r  <= 1'b0;
      end
      // busy or illegal orders are dropped, never sent to the flash
      if (start && (st_r != S_IDLE || !legal)) refuse_r <= 1'b1;
      if (abort_done) err_r <= 1'b1;
      // a 1 that stayed 0 means an attempt to program a cleared bit
      if (fin && cyc.rdata != sd_r[last_r]) pfail_r <= 1'b1;
      if (cyc_done && st_r != S_ABORT) rdata_r <= cyc.rdata;
    end
  end

  always_comb begin
    stat = 32'h0000_0000;
    stat[`HFC_ST_BUSY]   = st_r != S_IDLE;
    stat[`HFC_ST_ERR]    = err_r;
    stat[`HFC_ST_REFUSE] = refuse_r;
    stat[`HFC_ST_PFAIL]  = pfail_r;
    stat[`HFC_ST_SEC]    = sec_r;
    stat[`HFC_ST_ACCEL]  = accel;
    stat[`HFC_ST_RYBY]   = ready_busy_n;
    for (int i = 0; i < NB; i++) begin
      stat[8 + 2*i +: 2]  = mode_r[i];
      stat[16 + 2*i +: 2] = susp_r[i];
    end
  end
endmodule

// ### hfc_params.svh
// constants for the flash host command controller
`ifndef HFC_PARAMS_SVH
`define HFC_PARAMS_SVH

`define HFC_AW          22
`define HFC_DW          16
`define HFC_PAW         8
`define HFC_BANK_HI     21
`define HFC_BANK_LO     20
`define HFC_NBANK       4
`define HFC_SEQ_MAX     4

`define HFC_OFS_CTRL    8'h00
`define HFC_OFS_ADDR    8'h04
`define HFC_OFS_DATA    8'h08
`define HFC_OFS_CODE    8'h0C
`define HFC_OFS_CODE2   8'h10
`define HFC_OFS_UNLK1   8'h14
`define HFC_OFS_UNLK2   8'h18
`define HFC_OFS_STAT    8'h1C
`define HFC_OFS_RDATA   8'h20

`define HFC_CTRL_OP     3:0
`define HFC_CTRL_ACCEL  8
`define HFC_UNLK_ADDR   15:0
`define HFC_UNLK_DATA   23:16
`define HFC_CODE_AUTO   7:0
`define HFC_CODE_SECIN  15:8
`define HFC_CODE_SECXA  23:16
`define HFC_CODE_SECXB  31:24
`define HFC_CODE2_PSET  7:0
`define HFC_CODE2_BRA   15:8
`define HFC_CODE2_BRB   23:16
`define HFC_CODE2_PSUS  31:24

`define HFC_ST_BUSY     0
`define HFC_ST_ERR      1
`define HFC_ST_REFUSE   2
`define HFC_ST_PFAIL    3
`define HFC_ST_SEC      4
`define HFC_ST_ACCEL    5
`define HFC_ST_RYBY     6

`define HFC_DQ_TOGGLE   6
`define HFC_DQ_TIMEOUT  5

`define HFC_RESET_CMD   8'hF0
`define HFC_BYPIN_CMD   8'h20
`define HFC_BYPPG_CMD   8'hA0
`define HFC_ESUS_CMD    8'hB0

`define HFC_UNLK_RST    32'h0000_0000
`define HFC_CODE_RST    32'h0000_0000

`define HFC_CLK_NS      20
`define HFC_TWP_NS      40
`define HFC_TACC_NS     60
`define HFC_TWP_CYC  ((`HFC_TWP_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS)
`define HFC_TACC_CYC ((`HFC_TACC_NS + `HFC_CLK_NS - 1) / `HFC_CLK_NS)

`endif

// ### hfc_pkg.sv
// types for the flash host command controller
package hfc_pkg;
  typedef enum logic [3:0] {
    OP_RAW_WR, OP_READ, OP_RESET, OP_AUTOSEL, OP_BYP_ENTER, OP_SEC_ENTER,
    OP_SEC_EXIT, OP_PROGRAM, OP_BYP_PROG, OP_BYP_RESET, OP_ESUSP, OP_PSUSP
  } hfc_op_t;
  typedef enum logic [1:0] {M_READ, M_AUTO, M_BYP, M_BUSY} hfc_mode_t;
  typedef enum logic [1:0] {SU_NONE, SU_ERASE, SU_PROG} hfc_susp_t;
  typedef enum logic [2:0] {
    S_IDLE, S_CYC, S_POLL, S_ABORT
  } hfc_state_t;
  typedef enum logic [2:0] {
    C_IDLE, C_SET, C_WLOW, C_HOLD, C_READ, C_REL
  } hfc_cstate_t;
endpackage

// ### hfc_cyc_if.sv
// one flash bus cycle request between controller and cycle engine
`timescale 1ns/1ps
`include "hfc_params.svh"
interface hfc_cyc_if;
  logic                req;
  logic                wr;
  logic [`HFC_AW-1:0]  addr;
  logic [`HFC_DW-1:0]  wdata;
  logic                done;
  logic [`HFC_DW-1:0]  rdata;
  modport master (output req, wr, addr, wdata, input done, rdata);
  modport slave  (input req, wr, addr, wdata, output done, rdata);
endinterface

// ### hfc_cycle.sv
// strobe timing engine for single flash read and write cycles
`timescale 1ns/1ps
`include "hfc_params.svh"
module hfc_cycle (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  hfc_cyc_if.slave              cyc,
  output logic [`HFC_AW-1:0]    fl_addr,
  input  wire logic [`HFC_DW-1:0] fl_dq_i,
  output logic [`HFC_DW-1:0]    fl_dq_o,
  output logic                  fl_dq_oe_n,
  output logic                  fl_ce_n,
  output logic                  fl_we_n,
  output logic                  fl_oe_n
);
  import hfc_pkg::*;
  localparam logic [3:0] WP_CYC  = 4'(`HFC_TWP_CYC);
  localparam logic [3:0] ACC_CYC = 4'(`HFC_TACC_CYC);

  hfc_cstate_t st_r;
  logic [3:0]  cnt_r;
  logic        wr_r;
  logic        done_r;
  logic [`HFC_DW-1:0] rdata_r;

  assign cyc.done  = done_r;
  assign cyc.rdata = rdata_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_r       <= C_IDLE;
      cnt_r      <= 4'h0;
      wr_r       <= 1'b0;
      done_r     <= 1'b0;
      rdata_r    <= '0;
      fl_addr    <= '0;
      fl_dq_o    <= '0;
      fl_dq_oe_n <= 1'b1;
      fl_ce_n    <= 1'b1;
      fl_we_n    <= 1'b1;
      fl_oe_n    <= 1'b1;
    end else begin
      done_r <= 1'b0;
      case (st_r)
        C_IDLE: begin
          if (cyc.req) begin
            // chip select falls first so we_n falls later and takes address
            fl_addr    <= cyc.addr;
            fl_dq_o    <= cyc.wdata;
            fl_dq_oe_n <= !cyc.wr;
            fl_ce_n    <= 1'b0;
            wr_r       <= cyc.wr;
            st_r       <= C_SET;
          end
        end
        C_SET: begin
          cnt_r <= 4'h1;
          if (wr_r) begin
            fl_we_n <= 1'b0;
            st_r    <= C_WLOW;
          end else begin
            fl_oe_n <= 1'b0;
            st_r    <= C_READ;
          end
        end
        C_WLOW: begin
          if (cnt_r >= WP_CYC) begin
            // we_n rises ahead of ce_n, data still held: data taken here
            fl_we_n <= 1'b1;
            st_r    <= C_HOLD;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        C_HOLD: begin
          fl_ce_n <= 1'b1;
          st_r    <= C_REL;
        end
        C_READ: begin
          if (cnt_r >= ACC_CYC) begin
            rdata_r <= fl_dq_i;
            fl_oe_n <= 1'b1;
            fl_ce_n <= 1'b1;
            st_r    <= C_REL;
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        C_REL: begin
          fl_dq_oe_n <= 1'b1;
          done_r     <= 1'b1;
          st_r       <= C_IDLE;
        end
        default: st_r <= C_IDLE;
      endcase
    end
  end
endmodule

// ### hfc_ctrl_checker.sv
// pin and bus protocol checker for the flash host controller
`timescale 1ns/1ps
`include "hfc_params.svh"
module hfc_ctrl_chk (
  input wire logic                ref_clk,
  input wire logic                rstn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic [`HFC_PAW-1:0] paddr,
  input wire logic                pslverr,
  input wire logic [`HFC_AW-1:0]  fl_addr,
  input wire logic [`HFC_DW-1:0]  fl_dq_o,
  input wire logic                fl_dq_oe_n,
  input wire logic                fl_ce_n,
  input wire logic                fl_we_n,
  input wire logic                fl_oe_n
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_we_in_ce: assert property (!fl_we_n |-> !fl_ce_n)
    else $error("write strobe outside chip select");
  a_we_width: assert property ($fell(fl_we_n) |->
    !fl_we_n[*2] ##1 fl_we_n) else $error("write pulse width wrong");
  a_addr_hold: assert property (!fl_we_n |->
    $stable(fl_addr) && $stable(fl_dq_o)) else $error("write data moved");
  a_dq_driven: assert property (!fl_we_n |-> !fl_dq_oe_n)
    else $error("data not driven in write");
  a_strobe_excl: assert property (fl_oe_n || fl_we_n)
    else $error("read and write strobes together");
  a_oe_width: assert property ($fell(fl_oe_n) |->
    !fl_oe_n[*3] ##1 fl_oe_n) else $error("read pulse width wrong");
  a_no_fight: assert property (!fl_oe_n |-> fl_dq_oe_n)
    else $error("bus driven during read");
  a_ce_gap: assert property ($rose(fl_ce_n) |=> fl_ce_n)
    else $error("no idle clock between cycles");
  a_slv_err: assert property (psel && penable && paddr[1:0] == 2'b00
    |-> pslverr == (paddr > `HFC_OFS_RDATA)) else $error("bad pslverr");
  c_write: cover property ($fell(fl_we_n));
  c_read: cover property ($fell(fl_oe_n));
  c_err: cover property (pslverr);
endmodule
bind hfc_ctrl hfc_ctrl_chk u_chk (.ref_clk, .rstn, .psel, .penable, .paddr,
  .pslverr, .fl_addr, .fl_dq_o, .fl_dq_oe_n, .fl_ce_n, .fl_we_n, .fl_oe_n);

// ### hfc_flash_model.sv
// behavioural multi-bank nor flash seen from its pins
`timescale 1ns/1ps
module hfc_flash_model #(
  parameter logic [15:0] U1A = 16'h0123, U2A = 16'h0321,
  parameter logic [15:0] ID = 16'h00C3, // arbitrary code value
  parameter logic [7:0] U1D = 8'h5A, U2D = 8'hA5, AUTO = 8'h61, SIN = 8'h62,
  parameter logic [7:0] SXA = 8'h63, SXB = 8'h64, PSET = 8'h65,
  parameter logic [7:0] BRA = 8'h66, BRB = 8'h67
) (
  input  wire logic [21:0] fl_addr,
  input  wire logic [15:0] fl_dq_o,
  input  wire logic        fl_ce_n,
  input  wire logic        fl_we_n,
  input  wire logic        fl_oe_n,
  input  wire logic        accel_high_voltage,
  output logic [15:0]      fl_dq_i,
  output logic             ready_busy_n
);
  import hfc_pkg::*;
  logic [15:0] mem [16];
  hfc_mode_t   bm [4];
  logic [21:0] al;
  logic [2:0]  cyc;
  logic [1:0]  bk;
  logic        sec, act, tg, ef;
  logic [15:0] dout;
  int          busy, wr_count;
  initial begin
    foreach (mem[i]) mem[i] = 16'hFFFF;
    foreach (bm[i]) bm[i] = M_READ;
    cyc = 0;
    sec = 0;
    act = 0;
    tg = 0;
    ef = 0;
    busy = 0;
    wr_count = 0;
    dout = 0;
  end
  // released bus shows the inverse, never a stale copy
  assign fl_dq_i = (!fl_ce_n && !fl_oe_n) ? dout : ~dout;
  assign ready_busy_n = (busy == 0);
  task automatic prog(input logic [15:0] d);
    mem[al[3:0]] = mem[al[3:0]] & d;
    busy = 3;
    ef = al[3:0] == 4'h7; // worn word never finishes
    cyc = 0;
  endtask
  task automatic cmd(input logic [15:0] d);
    bk = al[21:20];
    if (d[7:0] == 8'hF0 && bm[bk] != M_BYP) begin
      foreach (bm[i]) if (bm[i] == M_AUTO) bm[i] = M_READ;
      cyc = 0;
    end else if (bm[bk] == M_BYP || accel_high_voltage) begin
      if (cyc == 3) prog(d);
      else if (cyc == 5 && d[7:0] == BRB) bm[bk] = M_READ;
      else if (d[7:0] == 8'hA0) cyc = 3;
      else if (d[7:0] == BRA) cyc = 5;
      if (cyc == 5 && bm[bk] == M_READ) cyc = 0;
    end else case (cyc)
      0: cyc = (al[15:0] == U1A && d[7:0] == U1D) ? 3'd1 : 3'd0;
      1: cyc = (al[15:0] == U2A && d[7:0] == U2D) ? 3'd2 : 3'd0;
      2: begin
        cyc = 0;
        if (d[7:0] == AUTO) bm[bk] = M_AUTO;
        else if (d[7:0] == 8'h20 && !sec) bm[bk] = M_BYP;
        else if (d[7:0] == SIN) sec = 1;
        else if (d[7:0] == SXA && sec) cyc = 6;
        else if (d[7:0] == PSET) cyc = 3;
      end
      3: prog(d);
      6: begin
        sec = (d[7:0] != SXB);
        cyc = 0;
      end
      default: cyc = 0;
    endcase
  endtask
  always @(negedge fl_we_n or negedge fl_ce_n)
    if (!fl_we_n && !fl_ce_n) begin
      al = fl_addr;
      act = 1;
    end
  always @(posedge fl_we_n or posedge fl_ce_n)
    if (act) begin
      act = 0;
      wr_count++;
      if (busy == 0) cmd(fl_dq_o);
      else if (ef && fl_dq_o[7:0] == 8'hF0) busy = 0;
    end
  always @(negedge fl_oe_n)
    if (!fl_ce_n) begin
      bk = fl_addr[21:20];
      if (busy != 0) begin
        if (!ef) busy--;
        tg = ~tg;
        dout = {8'h00, ~mem[fl_addr[3:0]][7], tg, ef, 5'h00};
      end
      else if (bm[bk] == M_AUTO) dout = ID;
      else dout = mem[fl_addr[3:0]];
    end
endmodule

// ### tb_top.sv
// self-checking bench for the flash host controller
`timescale 1ns/1ps
`include "hfc_params.svh"
module tb_top;
  import hfc_pkg::*;
  logic        ref_clk, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [21:0] fl_addr;
  logic [15:0] fl_dq_i, fl_dq_o;
  logic        fl_dq_oe_n, fl_ce_n, fl_we_n, fl_oe_n, err_v;
  logic        ready_busy_n, accel_high_voltage;
  int          bad_count, tests_run, w0;
  hfc_ctrl dut (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fl_addr, .fl_dq_i, .fl_dq_o, .fl_dq_oe_n,
    .fl_ce_n, .fl_we_n, .fl_oe_n, .ready_busy_n, .accel_high_voltage);
  hfc_flash_model u_flash (.fl_addr, .fl_dq_o, .fl_ce_n, .fl_we_n, .fl_oe_n,
    .accel_high_voltage, .fl_dq_i, .ready_busy_n);
  initial begin
    ref_clk = 0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] g, e, input string s);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, s, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `HFC_OFS_STAT, 32'h0);
      n++;
    end while (rd_v[`HFC_ST_BUSY] !== 1'b0 && n < 500);
    chk({31'h0, rd_v[`HFC_ST_BUSY]}, 32'h0, "still busy");
  endtask
  task automatic op(input logic [31:0] c);
    apb(1'b1, `HFC_OFS_CTRL, c);
    idle();
  endtask
  task automatic st(input logic [31:0] m, e, input string s);
    apb(1'b0, `HFC_OFS_STAT, 32'h0);
    chk(rd_v & m, e, s);
  endtask
  task automatic results;
    $display("mismatches %0d of %0d checks", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_setup;
    st(32'hFFFF_FFFF, 32'h0000_0040, "status after reset");
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err_v}, 32'h1, "unmapped access");
    apb(1'b1, `HFC_OFS_UNLK1, 32'h005A_0123);
    apb(1'b1, `HFC_OFS_UNLK2, 32'h00A5_0321);
    apb(1'b1, `HFC_OFS_CODE, 32'h6463_6261);
    apb(1'b1, `HFC_OFS_CODE2, 32'h6867_6665);
    apb(1'b0, `HFC_OFS_CODE2, 32'h0);
    chk(rd_v, 32'h6867_6665, "code readback");
  endtask
  task automatic t_program;
    w0 = u_flash.wr_count;
    apb(1'b1, `HFC_OFS_ADDR, 32'h0010_0005);
    apb(1'b1, `HFC_OFS_DATA, 32'h0000_1234);
    apb(1'b1, `HFC_OFS_CTRL, 32'h7);
    apb(1'b1, `HFC_OFS_CTRL, 32'h2);
    idle();
    chk(u_flash.wr_count - w0, 32'd4, "program cycles");
    chk({16'h0, u_flash.mem[5]}, 32'h1234, "programmed word");
    st(32'hFF0D, 32'h0004, "busy refusal only");
    apb(1'b1, `HFC_OFS_STAT, 32'hE);
    apb(1'b1, `HFC_OFS_DATA, 32'h0000_FFFF);
    op(32'h7);
    chk({16'h0, u_flash.mem[5]}, 32'h1234, "zeros stay");
    st(32'h8, 32'h8, "program fail flag");
    apb(1'b1, `HFC_OFS_ADDR, 32'h0010_0007);
    op(32'h7);
    st(32'hFF03, 32'h0002, "timeout aborted");
    chk(u_flash.busy, 32'h0, "device reset");
    apb(1'b1, `HFC_OFS_STAT, 32'hE);
    st(32'hE, 32'h0, "flags cleared");
  endtask
  task automatic t_autosel;
    apb(1'b1, `HFC_OFS_ADDR, 32'h0020_0000);
    op(32'h3);
    st(32'hFF00, 32'h1000, "bank two autoselect");
    op(32'h1);
    apb(1'b0, `HFC_OFS_RDATA, 32'h0);
    chk(rd_v & 32'hFFFF, 32'h00C3, "code read");
    apb(1'b1, `HFC_OFS_ADDR, 32'h0000_0000);
    op(32'h2);
    st(32'hFF00, 32'h0, "reset any address");
    chk({30'h0, u_flash.bm[2]}, 32'h0, "device bank back");
  endtask
  task automatic t_bypass;
    apb(1'b1, `HFC_OFS_ADDR, 32'h0010_0006);
    apb(1'b1, `HFC_OFS_DATA, 32'h0000_00F0);
    op(32'h4);
    st(32'hFF00, 32'h0800, "bank one bypass");
    chk({30'h0, u_flash.bm[1]}, 32'h2, "device in bypass");
    w0 = u_flash.wr_count;
    op(32'h7);
    st(32'h4, 32'h4, "plain program refused");
    op(32'h108);
    chk({31'h0, accel_high_voltage}, 32'h1, "accel request");
    chk(u_flash.wr_count - w0, 32'd2, "bypass cycles");
    chk({16'h0, u_flash.mem[6]}, 32'h00F0, "bypass word");
    op(32'h9);
    st(32'hFF20, 32'h0, "bypass left");
    chk({30'h0, u_flash.bm[1]}, 32'h0, "device left bypass");
    apb(1'b1, `HFC_OFS_STAT, 32'hE);
  endtask
  task automatic t_secure;
    w0 = u_flash.wr_count;
    op(32'h5);
    chk(u_flash.wr_count - w0, 32'd3, "enter cycles");
    st(32'h10, 32'h10, "secured on");
    op(32'h104);
    st(32'h804, 32'h4, "bypass refused");
    chk({31'h0, accel_high_voltage}, 32'h0, "accel blocked");
    w0 = u_flash.wr_count;
    op(32'h6);
    chk(u_flash.wr_count - w0, 32'd4, "exit cycles");
    st(32'h10, 32'h0, "secured off");
    chk({31'h0, u_flash.sec}, 32'h0, "device left region");
  endtask
  task automatic t_suspend;
    w0 = u_flash.wr_count;
    op(32'hA);
    st(32'hC_0000, 32'h4_0000, "erase suspend");
    apb(1'b1, `HFC_OFS_ADDR, 32'h0030_0000);
    op(32'hB);
    st(32'hC0_0000, 32'h80_0000, "program suspend");
    chk(u_flash.wr_count - w0, 32'd2, "suspend cycles");
  endtask
  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    results();
  end
  initial begin
    rstn = 0;
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    t_setup();
    t_program();
    t_autosel();
    t_bypass();
    t_secure();
    t_suspend();
    results();
  end
endmodule
